//--- core/nivu_pkg.sv
package nivu_pkg;

  // ********************************************************************
  // Special function register addresses
  // ********************************************************************
  localparam logic [7:0] SFR_EN_MAIN   = 8'hA8;
  localparam logic [7:0] SFR_PRI_MAIN  = 8'hB8;
  localparam logic [7:0] SFR_FLAGS     = 8'hC0;
  localparam logic [7:0] SFR_EN_PORT   = 8'hE8;
  localparam logic [7:0] SFR_POLARITY  = 8'hE9;
  localparam logic [7:0] SFR_PRI_PORT  = 8'hF8;

  // ********************************************************************
  // Field layout and reset values
  // ********************************************************************
  localparam int         GATE_BIT      = 7;
  localparam int         EXT0_BIT      = 0;
  localparam int         TIMER0_BIT    = 1;
  localparam int         EXT1_BIT      = 2;
  localparam int         TIMER1_BIT    = 3;
  localparam int         SERIAL_BIT    = 5;
  localparam logic [7:0] EN_MAIN_MASK  = 8'hAF;
  localparam logic [7:0] PRI_MAIN_MASK = 8'h2F;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         PORT_FIRST    = 2;

  // ********************************************************************
  // Polling slots, highest first
  // ********************************************************************
  localparam int NUM_SRC     = 13;
  localparam int SLOT_EXT0   = 0;
  localparam int SLOT_SERIAL = 1;
  localparam int SLOT_EXT5   = 2;
  localparam int SLOT_T0     = 3;
  localparam int SLOT_EXT6   = 4;
  localparam int SLOT_EXT1   = 5;
  localparam int SLOT_EXT2   = 6;
  localparam int SLOT_EXT7   = 7;
  localparam int SLOT_T1     = 8;
  localparam int SLOT_EXT3   = 9;
  localparam int SLOT_EXT8   = 10;
  localparam int SLOT_EXT4   = 11;
  localparam int SLOT_EXT9   = 12;

  // ********************************************************************
  // Vector addresses
  // ********************************************************************
  localparam logic [15:0] VEC_EXT0      = 16'h0003;
  localparam logic [15:0] VEC_T0        = 16'h000B;
  localparam logic [15:0] VEC_EXT1      = 16'h0013;
  localparam logic [15:0] VEC_T1        = 16'h001B;
  localparam logic [15:0] VEC_SERIAL    = 16'h002B;
  localparam logic [15:0] VEC_PORT_BASE = 16'h003B;
  localparam logic [15:0] VEC_PORT_STEP = 16'h0008;
  localparam logic [15:0] VEC_PORT_LAST = 16'h0073;

  // ********************************************************************
  // Nesting state and block state
  // ********************************************************************
  typedef enum logic [3:0] {
    NEST_IDLE     = 4'b0001,
    NEST_LOW      = 4'b0010,
    NEST_HIGH     = 4'b0100,
    NEST_LOW_HIGH = 4'b1000
  } nivu_nest_t;

  typedef struct packed {
    logic [7:0]  en_main;
    logic [7:0]  en_port;
    logic [7:0]  pri_main;
    logic [7:0]  pri_port;
    logic [7:0]  polarity;
    logic [7:0]  flags;
    logic [7:0]  act_prev;
    logic [7:0]  rdata;
    logic        req;
    logic        lvl;
    logic [15:0] vec;
    logic        wake;
    nivu_nest_t  nest;
  } nivu_state_t;

endpackage

//--- core/nivu_pick.sv
`timescale 1ns/1ns
module nivu_pick
(
  input  wire logic [12:0] pend,
  output logic             valid,
  output logic [3:0]       idx
);

  // Lowest slot number is the highest polling rank.
  always_comb
  begin
    valid = 1'b0;
    idx   = 4'h0;
    for (int i = nivu_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        valid = 1'b1;
        idx   = 4'(i);
      end
    end
  end

endmodule // nivu_pick

//--- core/nivu_core.sv
// Notes on behaviour
// - Flag register at C0H, bit7 source 9.
// - Each source vectors to its fixed address.
// - Fixed polling order within one priority level.
// - Registers decoded at their six fixed addresses.
// - Enabled port request sets flag; software clears.
// - Polarity bit 1 active high, 0 low.
// - Global gate bit 7 blocks all sources.
// - Priority bit selects level; port input wakes.
`timescale 1ns/1ns
module nivu_core
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  input  wire logic        external_input_zero,
  input  wire logic        external_input_one,
  input  wire logic        timer0_req,
  input  wire logic        timer1_req,
  input  wire logic        serial_req,
  input  wire logic [7:0]  port_external_input,
  output logic             int_req,
  output logic [15:0]      int_vector,
  input  wire logic        int_ack,
  input  wire logic        int_return,
  output logic             wake_up
);

  // ********************************************************************
  // Slot mapping and vector lookup
  // ********************************************************************
  // Main byte uses the enable register layout; port byte bit k is source
  // k+2.
  function automatic logic [12:0] slot_map(input logic [7:0] mb,
                                           input logic [7:0] pb);
    logic [12:0] s;
    s                         = 13'h0000;
    s[nivu_pkg::SLOT_EXT0]    = mb[nivu_pkg::EXT0_BIT];
    s[nivu_pkg::SLOT_SERIAL]  = mb[nivu_pkg::SERIAL_BIT];
    s[nivu_pkg::SLOT_T0]      = mb[nivu_pkg::TIMER0_BIT];
    s[nivu_pkg::SLOT_EXT1]    = mb[nivu_pkg::EXT1_BIT];
    s[nivu_pkg::SLOT_T1]      = mb[nivu_pkg::TIMER1_BIT];
    s[nivu_pkg::SLOT_EXT2]    = pb[0];
    s[nivu_pkg::SLOT_EXT3]    = pb[1];
    s[nivu_pkg::SLOT_EXT4]    = pb[2];
    s[nivu_pkg::SLOT_EXT5]    = pb[3];
    s[nivu_pkg::SLOT_EXT6]    = pb[4];
    s[nivu_pkg::SLOT_EXT7]    = pb[5];
    s[nivu_pkg::SLOT_EXT8]    = pb[6];
    s[nivu_pkg::SLOT_EXT9]    = pb[7];
    return s;
  endfunction

  function automatic logic [15:0] port_vec(input int n);
    return 16'(nivu_pkg::VEC_PORT_BASE +
               nivu_pkg::VEC_PORT_STEP * 16'(n - nivu_pkg::PORT_FIRST));
  endfunction

  function automatic logic [15:0] slot_vec(input logic [3:0] idx);
    logic [15:0] v;
    case (int'(idx))
      nivu_pkg::SLOT_EXT0:   v = nivu_pkg::VEC_EXT0;
      nivu_pkg::SLOT_SERIAL: v = nivu_pkg::VEC_SERIAL;
      nivu_pkg::SLOT_T0:     v = nivu_pkg::VEC_T0;
      nivu_pkg::SLOT_EXT1:   v = nivu_pkg::VEC_EXT1;
      nivu_pkg::SLOT_T1:     v = nivu_pkg::VEC_T1;
      nivu_pkg::SLOT_EXT2:   v = port_vec(2);
      nivu_pkg::SLOT_EXT3:   v = port_vec(3);
      nivu_pkg::SLOT_EXT4:   v = port_vec(4);
      nivu_pkg::SLOT_EXT5:   v = port_vec(5);
      nivu_pkg::SLOT_EXT6:   v = port_vec(6);
      nivu_pkg::SLOT_EXT7:   v = port_vec(7);
      nivu_pkg::SLOT_EXT8:   v = port_vec(8);
      nivu_pkg::SLOT_EXT9:   v = port_vec(9);
      default:               v = nivu_pkg::VEC_EXT0;
    endcase
    return v;
  endfunction

  // ********************************************************************
  // State and candidate selection
  // ********************************************************************
  nivu_pkg::nivu_state_t state_r;
  nivu_pkg::nivu_state_t state_nxt;
  logic [7:0]            main_req;
  logic [7:0]            act;
  logic [12:0]           pend;
  logic [12:0]           hi_sel;
  logic                  hi_valid;
  logic [3:0]            hi_idx;
  logic                  lo_valid;
  logic [3:0]            lo_idx;
  logic                  flag_wr;

  always_comb
  begin
    main_req                        = 8'h00;
    main_req[nivu_pkg::EXT0_BIT]    = external_input_zero;
    main_req[nivu_pkg::TIMER0_BIT]  = timer0_req;
    main_req[nivu_pkg::EXT1_BIT]    = external_input_one;
    main_req[nivu_pkg::TIMER1_BIT]  = timer1_req;
    main_req[nivu_pkg::SERIAL_BIT]  = serial_req;
  end

  assign act     = ~(port_external_input ^ state_r.polarity);
  assign flag_wr = sfr_wr && (sfr_addr == nivu_pkg::SFR_FLAGS);
  assign pend    = slot_map(main_req, state_r.flags)
                 & slot_map(state_r.en_main, state_r.en_port)
                 & {13{state_r.en_main[nivu_pkg::GATE_BIT]}};
  assign hi_sel  = slot_map(state_r.pri_main, state_r.pri_port);

  // Two encoders keep each level's polling order independent.
  nivu_pick u_pick_hi
  (
    .pend  (pend & hi_sel),
    .valid (hi_valid),
    .idx   (hi_idx)
  );

  nivu_pick u_pick_lo
  (
    .pend  (pend & ~hi_sel),
    .valid (lo_valid),
    .idx   (lo_idx)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb
  begin
    logic       cand_valid;
    logic       cand_hi;
    logic [3:0] cand_idx;
    state_nxt  = state_r;
    cand_valid = 1'b0;
    cand_hi    = 1'b0;
    cand_idx   = 4'h0;

    if (sfr_rd)
    begin
      case (sfr_addr)
        nivu_pkg::SFR_EN_MAIN:  state_nxt.rdata = state_r.en_main;
        nivu_pkg::SFR_PRI_MAIN: state_nxt.rdata = state_r.pri_main;
        nivu_pkg::SFR_FLAGS:    state_nxt.rdata = state_r.flags;
        nivu_pkg::SFR_EN_PORT:  state_nxt.rdata = state_r.en_port;
        nivu_pkg::SFR_POLARITY: state_nxt.rdata = state_r.polarity;
        nivu_pkg::SFR_PRI_PORT: state_nxt.rdata = state_r.pri_port;
        default:                state_nxt.rdata = 8'h00;
      endcase
    end

    if (sfr_wr)
    begin
      case (sfr_addr)
        nivu_pkg::SFR_EN_MAIN:
          state_nxt.en_main = sfr_wdata & nivu_pkg::EN_MAIN_MASK;
        nivu_pkg::SFR_PRI_MAIN:
          state_nxt.pri_main = sfr_wdata & nivu_pkg::PRI_MAIN_MASK;
        nivu_pkg::SFR_EN_PORT:  state_nxt.en_port  = sfr_wdata;
        nivu_pkg::SFR_POLARITY: state_nxt.polarity = sfr_wdata;
        nivu_pkg::SFR_PRI_PORT: state_nxt.pri_port = sfr_wdata;
        default:                state_nxt.en_main  = state_r.en_main;
      endcase
    end

    // A request arriving with a software clear still lands.
    state_nxt.flags = (flag_wr ? sfr_wdata : state_r.flags)
                    | (act & ~state_r.act_prev & state_r.en_port);
    state_nxt.act_prev = act;
    state_nxt.wake     = |(act & state_r.en_port);

    // Only a high request may enter over a low routine.
    case (state_r.nest)
      nivu_pkg::NEST_IDLE:
      begin
        cand_valid = hi_valid || lo_valid;
        cand_hi    = hi_valid;
        cand_idx   = hi_valid ? hi_idx : lo_idx;
      end
      nivu_pkg::NEST_LOW:
      begin
        cand_valid = hi_valid;
        cand_hi    = 1'b1;
        cand_idx   = hi_idx;
      end
      default:
        cand_valid = 1'b0;
    endcase

    state_nxt.req = cand_valid && !(int_ack && state_r.req);
    if (cand_valid)
    begin
      state_nxt.lvl = cand_hi;
      state_nxt.vec = slot_vec(cand_idx);
    end

    if (int_ack && state_r.req)
    begin
      case (state_r.nest)
        nivu_pkg::NEST_IDLE:
          state_nxt.nest = state_r.lvl ? nivu_pkg::NEST_HIGH
                                       : nivu_pkg::NEST_LOW;
        nivu_pkg::NEST_LOW:
          state_nxt.nest = nivu_pkg::NEST_LOW_HIGH;
        default:
          state_nxt.nest = state_r.nest;
      endcase
    end
    else if (int_return)
    begin
      case (state_r.nest)
        nivu_pkg::NEST_LOW_HIGH: state_nxt.nest = nivu_pkg::NEST_LOW;
        default:                 state_nxt.nest = nivu_pkg::NEST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r          <= '0;
      state_r.en_main  <= nivu_pkg::REG_RESET;
      state_r.en_port  <= nivu_pkg::REG_RESET;
      state_r.pri_main <= nivu_pkg::REG_RESET;
      state_r.pri_port <= nivu_pkg::REG_RESET;
      state_r.polarity <= nivu_pkg::REG_RESET;
      state_r.flags    <= nivu_pkg::REG_RESET;
      state_r.nest     <= nivu_pkg::NEST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign sfr_rdata  = state_r.rdata;
  assign int_req    = state_r.req;
  assign int_vector = state_r.vec;
  assign wake_up    = state_r.wake;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  gate_closed_a: assert property (
    !state_r.en_main[nivu_pkg::GATE_BIT] |=> !int_req)
    else $error("request raised with global gate closed");

  flag_sticky_a: assert property (
    !flag_wr |=> ((state_r.flags & $past(state_r.flags))
                  == $past(state_r.flags)))
    else $error("port flag cleared without software write");

  flag_cause_a: assert property (
    $rose(state_r.flags[0]) && !$past(flag_wr)
      |-> $past(state_r.en_port[0]) && $past(act[0]))
    else $error("port flag set without enabled active input");

  vec_form_a: assert property (
    int_req |-> int_vector[2:0] == 3'h3
                && int_vector <= nivu_pkg::VEC_PORT_LAST)
    else $error("vector outside the fixed table");

  high_locked_a: assert property (
    (state_r.nest == nivu_pkg::NEST_HIGH ||
     state_r.nest == nivu_pkg::NEST_LOW_HIGH) |=> !int_req)
    else $error("request raised over a high routine");

  low_preempt_a: assert property (
    int_req && $past(state_r.nest) == nivu_pkg::NEST_LOW
      |-> state_r.lvl)
    else $error("low request raised over a low routine");

  poll_order_a: assert property (
    pend[nivu_pkg::SLOT_EXT0] && (hi_sel[nivu_pkg::SLOT_EXT0] || !hi_valid)
      && state_r.nest == nivu_pkg::NEST_IDLE
      |=> int_vector == nivu_pkg::VEC_EXT0)
    else $error("top slot lost the poll");

  flag_read_a: assert property (
    sfr_rd && sfr_addr == nivu_pkg::SFR_FLAGS
      |=> sfr_rdata == $past(state_r.flags))
    else $error("flag register read back wrong");

endmodule // nivu_core

//--- sim/nivu_cpu_model.sv
`timescale 1ns/1ns
module nivu_cpu_model
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        auto_ack,
  input  wire logic        int_req,
  input  wire logic [15:0] int_vector,
  output logic             int_ack,
  output logic [15:0]      last_vec
);
  // One pulse per grant; the idle cycle after it lets the request drop,
  // so a standing request is never taken twice.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      int_ack  <= 1'b0;
      last_vec <= 16'h0000;
    end
    else if (int_ack)
      int_ack <= 1'b0;
    else if (auto_ack && int_req)
    begin
      int_ack  <= 1'b1;
      last_vec <= int_vector;
    end
  end
endmodule // nivu_cpu_model

//--- sim/test_nested_interrupt_vector_unit.sv
`timescale 1ns/1ns
module test_nested_interrupt_vector_unit;
  logic        core_clk   = 1'b0;
  logic        srst       = 1'b1;
  logic [7:0]  sfr_addr   = 8'h00;
  logic        sfr_wr     = 1'b0;
  logic        sfr_rd     = 1'b0;
  logic [7:0]  sfr_wdata  = 8'h00;
  logic [4:0]  main_src   = 5'h00;
  logic [7:0]  pins       = 8'h00;
  logic        int_return = 1'b0;
  logic        auto_ack   = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        int_req;
  logic [15:0] int_vector;
  logic        int_ack;
  logic        wake_up;
  logic [15:0] last_vec;
  int          fail_count = 0;
  int          checked    = 0;

  nivu_core u_dut (.core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .external_input_zero(main_src[0]),
    .timer0_req(main_src[1]), .external_input_one(main_src[2]),
    .timer1_req(main_src[3]), .serial_req(main_src[4]),
    .port_external_input(pins), .int_req(int_req), .int_vector(int_vector),
    .int_ack(int_ack), .int_return(int_return), .wake_up(wake_up));
  nivu_cpu_model u_cpu (.core_clk(core_clk), .srst(srst),
    .auto_ack(auto_ack), .int_req(int_req), .int_vector(int_vector),
    .int_ack(int_ack), .last_vec(last_vec));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse_ret();
    @(posedge core_clk) int_return <= 1'b1;
    @(posedge core_clk) int_return <= 1'b0;
  endtask
  task automatic do_reset(input int n);
    @(posedge core_clk);
    srst     <= 1'b1;
    main_src <= 5'h00;
    pins     <= 8'h00;
    auto_ack <= 1'b0;
    repeat (n) @(posedge core_clk);
    srst <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic test_regs();
    logic [7:0] ad [7] = '{8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9, 8'hF8, 8'h90};
    logic [7:0] wd [7] = '{8'hFF, 8'hFF, 8'h81, 8'h5A, 8'hA5, 8'h3C, 8'h77};
    logic [7:0] rv [7] = '{8'hAF, 8'h2F, 8'h81, 8'h5A, 8'hA5, 8'h3C, 8'h00};
    // Enabled and newly active-high pins are disjoint, so no flag moves.
    @(posedge core_clk) pins <= 8'hFF;
    foreach (ad[i]) rdc(ad[i], 8'h00);
    foreach (ad[i]) wr(ad[i], wd[i]);
    foreach (ad[i]) rdc(ad[i], rv[i]);
    $display("test regs done");
  endtask
  task automatic test_gate();
    wr(8'hA8, 8'h01);
    @(posedge core_clk) main_src <= 5'h01;
    settle();
    chk({15'h0000, int_req}, 16'h0000);
    wr(8'hA8, 8'h81);
    settle();
    chk({15'h0000, int_req}, 16'h0001);
    chk(int_vector, 16'h0003);
    wr(8'hA8, 8'h01);
    settle();
    chk({15'h0000, int_req}, 16'h0000);
    $display("test gate done");
  endtask
  task automatic test_order();
    int          code [13] = '{0, 4, 11, 1, 12, 2, 8, 13, 3, 9, 14, 10, 15};
    logic [15:0] mv [5] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h002B};
    logic [15:0] exp;
    logic [7:0]  pf;
    pf = 8'hFF;
    wr(8'hE9, 8'hFF);
    wr(8'hE8, 8'hFF);
    wr(8'hA8, 8'hAF);
    @(posedge core_clk) pins <= 8'hFF;
    @(posedge core_clk) main_src <= 5'h1F;
    settle();
    rdc(8'hC0, 8'hFF);
    foreach (code[i])
    begin
      if (code[i] < 8)
        exp = mv[code[i]];
      else
        exp = 16'h003B + 16'(8 * (code[i] - 8));
      chk(int_vector, exp);
      chk({15'h0000, int_req}, 16'h0001);
      if (code[i] < 8)
        @(posedge core_clk) main_src[code[i]] <= 1'b0;
      else
      begin
        pf[code[i] - 8] = 1'b0;
        wr(8'hC0, pf);
      end
      settle();
    end
    chk({15'h0000, int_req}, 16'h0000);
    $display("test order done");
  endtask
  task automatic test_polarity();
    @(posedge core_clk) pins <= 8'hFF;
    wr(8'hE8, 8'h01);
    wr(8'hA8, 8'h80);
    settle();
    rdc(8'hC0, 8'h00);
    @(posedge core_clk) pins[0] <= 1'b0;
    settle();
    rdc(8'hC0, 8'h01);
    chk({15'h0000, wake_up}, 16'h0001);
    chk(int_vector, 16'h003B);
    // Pin 0 returns idle while disabled pin 1 goes active.
    @(posedge core_clk) pins <= 8'hFD;
    settle();
    rdc(8'hC0, 8'h01);
    chk({15'h0000, wake_up}, 16'h0000);
    wr(8'hC0, 8'h00);
    rdc(8'hC0, 8'h00);
    wr(8'hE9, 8'h01);
    settle();
    rdc(8'hC0, 8'h01);
    // A clear that meets a fresh request must leave the flag set.
    @(posedge core_clk) pins[0] <= 1'b0;
    @(posedge core_clk)
    begin
      pins[0]   <= 1'b1;
      sfr_addr  <= 8'hC0;
      sfr_wdata <= 8'h00;
      sfr_wr    <= 1'b1;
    end
    @(posedge core_clk) sfr_wr <= 1'b0;
    rdc(8'hC0, 8'h01);
    $display("test polarity done");
  endtask
  task automatic test_nest();
    wr(8'hA8, 8'hA7);
    wr(8'hB8, 8'h22);
    @(posedge core_clk) auto_ack <= 1'b1;
    @(posedge core_clk) main_src <= 5'h04;
    settle();
    chk(last_vec, 16'h0013);
    @(posedge core_clk) main_src <= 5'h01;
    settle();
    chk({15'h0000, int_req}, 16'h0000);
    @(posedge core_clk) main_src <= 5'h03;
    settle();
    chk(last_vec, 16'h000B);
    @(posedge core_clk) main_src <= 5'h13;
    settle();
    chk(last_vec, 16'h000B);
    @(posedge core_clk) main_src <= 5'h01;
    pulse_ret();
    settle();
    chk({15'h0000, int_req}, 16'h0000);
    pulse_ret();
    settle();
    chk(last_vec, 16'h0003);
    // A high grant from idle must lock out every later request.
    @(posedge core_clk) main_src <= 5'h00;
    pulse_ret();
    settle();
    @(posedge core_clk) main_src <= 5'h02;
    settle();
    chk(last_vec, 16'h000B);
    @(posedge core_clk) main_src <= 5'h13;
    settle();
    chk({15'h0000, int_req}, 16'h0000);
    pulse_ret();
    settle();
    chk(last_vec, 16'h002B);
    $display("test nest done");
  endtask

  initial
  begin
    #20000;
    fail_count++;
    $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  end

  initial
  begin
    do_reset(12);
    test_regs();
    do_reset(2);
    test_gate();
    do_reset(2);
    test_order();
    do_reset(2);
    test_polarity();
    do_reset(2);
    test_nest();
    stop_test();
  end
endmodule // test_nested_interrupt_vector_unit
